// >>> rtc_map.vh
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// crystal rate and the tick period it is divided down to
`define XTAL_HZ        32768
`define TICK_S         1
`define PRE_DIV        16'h8000 // crystal rate times tick period, at prescaler width
`define PRE_W          16

// counter widths
`define SEC_W          6
`define MIN_W          6
`define HR_W           5
`define DAY_W          15
`define SW_W           16

// last state of the second, minute, hour and day counter stages
`define SEC_LAST       6'h3b
`define MIN_LAST       6'h3b
`define HR_LAST        5'h17
`define DAY_LAST       15'h7fff

// time-of-day word layout
`define SEC_LSB        0
`define SEC_MSB        5
`define MIN_LSB        8
`define MIN_MSB        13
`define HR_LSB         16
`define HR_MSB         20

// register byte offsets
`define ADDR_W         12
`define A_TIME         12'h000
`define A_DAY          12'h004
`define A_ALM1         12'h008
`define A_ALM2         12'h00c
`define A_ALM2_DAY     12'h010
`define A_SW           12'h014
`define A_CTRL         12'h018
`define A_STATUS       12'h01c
`define A_MASK         12'h020

// event bit positions in status and mask
`define EV_SEC         0
`define EV_MIN         1
`define EV_HR          2
`define EV_DAY         3
`define EV_ALM1        4
`define EV_ALM2        5
`define EV_SW          6
`define EV_W           7

// control bits
`define CTRL_W         1
`define CTRL_SW_RUN    0

// reset values
`define RST_WORD       32'h0000_0000
`define RST_EV         7'h00
`define RST_CTRL       1'h0

`endif

// >>> rtc_stage.v
// one wrapping counter stage with load and carry out
module rtc_stage #(
  parameter         W    = 6,
  parameter [W-1:0] LAST = {W{1'b1}}
) (
  input  wire         clk_i,
  input  wire         srst_i,
  input  wire         inc_i,
  input  wire         load_i,
  input  wire [W-1:0] load_val_i,
  output wire [W-1:0] cnt_o,
  output wire         carry_o
);

  reg  [W-1:0] cnt_r;
  // out-of-range loaded values wrap on the next step too
  wire         at_last = (cnt_r >= LAST);

  // load wins over a step in the same cycle
  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r <= {W{1'b0}};
    end else if (load_i) begin
      cnt_r <= load_val_i;
    end else if (inc_i) begin
      cnt_r <= at_last ? {W{1'b0}} : (cnt_r + {{(W-1){1'b0}}, 1'b1});
    end
  end

  assign cnt_o   = cnt_r;
  assign carry_o = inc_i & ~load_i & at_last;

endmodule // rtc_stage

// >>> rtc_sva.sv
`include "rtc_map.vh"
module rtc_sva #(
  parameter [`PRE_W-1:0] PRE_DIV = `PRE_DIV
) (
  input wire               clk_i,
  input wire               srst_i,
  input wire               psel_i,
  input wire               penable_i,
  input wire               pwrite_i,
  input wire [`ADDR_W-1:0] paddr_i,
  input wire [31:0]        pwdata_i,
  input wire [31:0]        prdata_o,
  input wire               pslverr_o,
  input wire               xtal_i,
  input wire               irq_o,
  input wire               wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // access phase decode
  wire       wr  = psel_i & penable_i & pwrite_i;
  wire       rd  = psel_i & penable_i & ~pwrite_i;
  wire       clr = wr & (paddr_i == `A_STATUS || paddr_i == `A_MASK);
  reg [6:0]  mask_r;
  reg [1:0]  xs_r;
  reg [15:0] xcnt_r;
  // mask mirror and crystal edge count
  always @(posedge clk_i) begin
    if (srst_i) begin
      mask_r <= 7'h00;
      xs_r <= 2'h0;
      xcnt_r <= 16'h0000;
    end else begin
      xs_r <= {xs_r[0], xtal_i};
      if (wr && paddr_i == `A_MASK)
        mask_r <= pwdata_i[6:0];
      if (xs_r == 2'h1 && xcnt_r != 16'hffff)
        xcnt_r <= xcnt_r + 16'h0001;
    end
  end
  wake_irq_a: assert property (wake_o == irq_o) else $error("wake differs");
  early_tick_a: assert property (xcnt_r < PRE_DIV - 1 |-> !irq_o) else $error("early");
  mask_gate_a: assert property ($rose(irq_o) |-> mask_r != 7'h00) else $error("gate");
  mask_off_a: assert property (wr && paddr_i == `A_MASK && pwdata_i[6:0] == 7'h00
    |-> ##2 !irq_o) else $error("mask off");
  level_hold_a: assert property ($fell(irq_o) |-> $past(clr, 2)) else $error("drop");
  time_rng_a: assert property (rd && paddr_i == `A_TIME
    |-> prdata_o[5:0] <= `SEC_LAST && prdata_o[13:8] <= `MIN_LAST) else $error("sec");
  hour_rng_a: assert property (rd && paddr_i == `A_TIME
    |-> prdata_o[20:16] <= `HR_LAST && prdata_o[31:21] == 11'h000) else $error("hr");
  day_wid_a: assert property (rd && paddr_i == `A_DAY |-> prdata_o[31:15] == 17'h0)
    else $error("day");
  stat_wid_a: assert property (rd && paddr_i == `A_STATUS |-> prdata_o[31:7] == 25'h0)
    else $error("status");
  cover property ($rose(irq_o));
  cover property (pslverr_o);
  cover property (rd && paddr_i == `A_SW);
endmodule // rtc_sva
bind rtc_watch_alarm_stopwatch rtc_sva #(.PRE_DIV(PRE_DIV)) chk (.clk_i(clk_i),
  .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .xtal_i(xtal_i), .irq_o(irq_o), .wake_o(wake_o));

// >>> rtc_watch_alarm_stopwatch.v
`include "rtc_map.vh"

module rtc_watch_alarm_stopwatch #(
  parameter [`PRE_W-1:0] PRE_DIV = `PRE_DIV
) (
  input  wire                clk_i,
  input  wire                srst_i,
  input  wire                psel_i,
  input  wire                penable_i,
  input  wire                pwrite_i,
  input  wire [`ADDR_W-1:0]  paddr_i,
  input  wire [31:0]         pwdata_i,
  output reg  [31:0]         prdata_o,
  output wire                pready_o,
  output wire                pslverr_o,
  input  wire                xtal_i,
  output wire                irq_o,
  output wire                wake_o
);

  // crystal synchroniser and edge detect
  reg                   xtal_s1_r;
  reg                   xtal_s2_r;
  reg                   xtal_d_r;
  wire                  xtal_rise;

  // counter chain
  wire                  tick;
  wire                  sec_carry;
  wire                  min_carry;
  wire                  hr_carry;
  wire [`SEC_W-1:0]     sec_cnt;
  wire [`MIN_W-1:0]     min_cnt;
  wire [`HR_W-1:0]      hr_cnt;
  wire [`DAY_W-1:0]     day_cnt;
  reg                   tick_d_r;

  // software registers
  reg  [31:0]           alm1_r;
  reg  [31:0]           alm2_r;
  reg  [`DAY_W-1:0]     alm2_day_r;
  reg  [`SW_W-1:0]      sw_r;
  reg  [`CTRL_W-1:0]    ctrl_r;
  reg  [`EV_W-1:0]      status_r;
  reg  [`EV_W-1:0]      mask_r;
  reg                   irq_r;

  // bus decode
  wire                  acc;
  wire                  wr_en;
  wire                  setup;
  reg                   mapped;
  reg  [31:0]           rd_nxt;
  wire                  wr_time;
  wire                  wr_day;
  wire                  wr_sw;
  wire                  wr_status;

  // events
  wire                  alm1_hit;
  wire                  alm2_hit;
  wire                  sw_zero;
  wire                  sw_ev;
  reg  [`EV_W-1:0]      ev_set;
  wire [`EV_W-1:0]      ev_clr;
  wire [`EV_W-1:0]      status_nxt;
  wire [31:0]           time_word;

  // two flops before the edge detector looks at the crystal
  always @(posedge clk_i) begin
    if (srst_i) begin
      xtal_s1_r <= 1'b0;
      xtal_s2_r <= 1'b0;
      xtal_d_r  <= 1'b0;
    end else begin
      xtal_s1_r <= xtal_i;
      xtal_s2_r <= xtal_s1_r;
      xtal_d_r  <= xtal_s2_r;
    end
  end

  assign xtal_rise = xtal_s2_r & ~xtal_d_r;

  rtc_stage #(
    .W    (`PRE_W),
    .LAST (PRE_DIV - {{(`PRE_W-1){1'b0}}, 1'b1})
  ) u_pre (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .inc_i      (xtal_rise),
    .load_i     (1'b0),
    .load_val_i ({`PRE_W{1'b0}}),
    .cnt_o      (),
    .carry_o    (tick)
  );

  // apb handshake and write strobes
  assign acc       = psel_i & penable_i;
  assign setup     = psel_i & ~penable_i;
  assign wr_en     = acc & pwrite_i;
  assign wr_time   = wr_en & (paddr_i == `A_TIME);
  assign wr_day    = wr_en & (paddr_i == `A_DAY);
  assign wr_sw     = wr_en & (paddr_i == `A_SW);
  assign wr_status = wr_en & (paddr_i == `A_STATUS);
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;

  rtc_stage #(
    .W    (`SEC_W),
    .LAST (`SEC_LAST)
  ) u_sec (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .inc_i      (tick),
    .load_i     (wr_time),
    .load_val_i (pwdata_i[`SEC_MSB:`SEC_LSB]),
    .cnt_o      (sec_cnt),
    .carry_o    (sec_carry)
  );

  rtc_stage #(
    .W    (`MIN_W),
    .LAST (`MIN_LAST)
  ) u_min (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .inc_i      (sec_carry),
    .load_i     (wr_time),
    .load_val_i (pwdata_i[`MIN_MSB:`MIN_LSB]),
    .cnt_o      (min_cnt),
    .carry_o    (min_carry)
  );

  rtc_stage #(
    .W    (`HR_W),
    .LAST (`HR_LAST)
  ) u_hr (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .inc_i      (min_carry),
    .load_i     (wr_time),
    .load_val_i (pwdata_i[`HR_MSB:`HR_LSB]),
    .cnt_o      (hr_cnt),
    .carry_o    (hr_carry)
  );

  rtc_stage #(
    .W    (`DAY_W),
    .LAST (`DAY_LAST)
  ) u_day (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .inc_i      (hr_carry),
    .load_i     (wr_day),
    .load_val_i (pwdata_i[`DAY_W-1:0]),
    .cnt_o      (day_cnt),
    .carry_o    ()
  );

  // packed time of day for readback and compare
  assign time_word = {{(31-`HR_MSB){1'b0}}, hr_cnt,
                      {(`HR_LSB-`MIN_MSB-1){1'b0}}, min_cnt,
                      {(`MIN_LSB-`SEC_MSB-1){1'b0}}, sec_cnt};

  // compare one cycle after the tick, once the counters have moved
  always @(posedge clk_i) begin
    if (srst_i) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick;
    end
  end

  assign alm1_hit = tick_d_r & (time_word == alm1_r);
  assign alm2_hit = tick_d_r & (time_word == alm2_r) & (day_cnt == alm2_day_r);

  assign sw_zero = (sw_r == {`SW_W{1'b0}});
  assign sw_ev   = ctrl_r[`CTRL_SW_RUN] & tick & sw_zero & ~wr_sw;

  always @(posedge clk_i) begin
    if (srst_i) begin
      sw_r <= {`SW_W{1'b0}};
    end else if (wr_sw) begin
      sw_r <= pwdata_i[`SW_W-1:0];
    end else if (ctrl_r[`CTRL_SW_RUN] & tick) begin
      sw_r <= sw_r - {{(`SW_W-1){1'b0}}, 1'b1}; // zero wraps to all ones
    end
  end

  // alarm, control and mask registers
  always @(posedge clk_i) begin
    if (srst_i) begin
      alm1_r     <= `RST_WORD;
      alm2_r     <= `RST_WORD;
      alm2_day_r <= {`DAY_W{1'b0}};
      ctrl_r     <= `RST_CTRL;
      mask_r     <= `RST_EV;
    end else if (wr_en) begin
      case (paddr_i)
        `A_ALM1: begin
          alm1_r <= pwdata_i & time_mask(1'b1);
        end
        `A_ALM2: begin
          alm2_r <= pwdata_i & time_mask(1'b1);
        end
        `A_ALM2_DAY: begin
          alm2_day_r <= pwdata_i[`DAY_W-1:0];
        end
        `A_CTRL: begin
          ctrl_r <= pwdata_i[`CTRL_W-1:0];
        end
        `A_MASK: begin
          mask_r <= pwdata_i[`EV_W-1:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // mask of the implemented time-of-day bits
  function [31:0] time_mask;
    input dummy;
    begin
      time_mask = 32'h0000_0000;
      time_mask[`SEC_MSB:`SEC_LSB] = {`SEC_W{dummy}};
      time_mask[`MIN_MSB:`MIN_LSB] = {`MIN_W{dummy}};
      time_mask[`HR_MSB:`HR_LSB]   = {`HR_W{dummy}};
    end
  endfunction

  always @* begin
    ev_set            = `RST_EV;
    ev_set[`EV_SEC]   = tick;
    ev_set[`EV_MIN]   = sec_carry;
    ev_set[`EV_HR]    = min_carry;
    ev_set[`EV_DAY]   = hr_carry;
    ev_set[`EV_ALM1]  = alm1_hit;
    ev_set[`EV_ALM2]  = alm2_hit;
    ev_set[`EV_SW]    = sw_ev;
  end

  assign ev_clr     = wr_status ? pwdata_i[`EV_W-1:0] : `RST_EV;
  assign status_nxt = (status_r & ~ev_clr) | ev_set;

  always @(posedge clk_i) begin
    if (srst_i) begin
      status_r <= `RST_EV;
    end else begin
      status_r <= status_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  assign irq_o  = irq_r;
  // plain level for any power state
  assign wake_o = irq_r;

  // read mux, sampled in the setup cycle
  always @* begin
    rd_nxt = `RST_WORD;
    mapped = 1'b1;
    case (paddr_i)
      `A_TIME: begin
        rd_nxt = time_word;
      end
      `A_DAY: begin
        rd_nxt[`DAY_W-1:0] = day_cnt;
      end
      `A_ALM1: begin
        rd_nxt = alm1_r;
      end
      `A_ALM2: begin
        rd_nxt = alm2_r;
      end
      `A_ALM2_DAY: begin
        rd_nxt[`DAY_W-1:0] = alm2_day_r;
      end
      `A_SW: begin
        rd_nxt[`SW_W-1:0] = sw_r;
      end
      `A_CTRL: begin
        rd_nxt[`CTRL_W-1:0] = ctrl_r;
      end
      `A_STATUS: begin
        rd_nxt[`EV_W-1:0] = status_r;
      end
      `A_MASK: begin
        rd_nxt[`EV_W-1:0] = mask_r;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read data register
  always @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= `RST_WORD;
    end else if (setup & ~pwrite_i) begin
      prdata_o <= rd_nxt;
    end
  end

endmodule // rtc_watch_alarm_stopwatch

// >>> rtc_watch_alarm_stopwatch_bench.sv
`include "rtc_map.vh"
module rtc_watch_alarm_stopwatch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 32; // four crystal edges of eight clocks
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  reg               clk_i;
  reg               srst_i;
  reg               psel_i;
  reg               penable_i;
  reg               pwrite_i;
  reg               xtal_i;
  reg [`ADDR_W-1:0] paddr_i;
  reg [31:0]        pwdata_i;
  wire [31:0]       prdata_o;
  wire              pready_o;
  wire              pslverr_o;
  wire              irq_o;
  wire              wake_o;
  reg [31:0]        rd_v;
  reg               err_v;
  int               err_total = 0;
  int               n_tests = 0;
  row_t rows[7] = '{'{`A_ALM1, 32'hffffffff, 32'h001f3f3f, 1'b0},
    '{`A_ALM2, 32'hffffffff, 32'h001f3f3f, 1'b0}, '{`A_ALM2_DAY, 32'hffffffff, 32'h7fff, 1'b0},
    '{`A_CTRL, 32'h0, 32'h0, 1'b0}, '{`A_MASK, 32'hff, 32'h7f, 1'b0},
    '{`A_MASK, 32'h0, 32'h0, 1'b0}, '{12'h024, 32'hffffffff, 32'h0, 1'b1}};
  rtc_watch_alarm_stopwatch #(.PRE_DIV(16'h0004)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .xtal_i(xtal_i), .irq_o(irq_o), .wake_o(wake_o));
  // system clock and slow crystal
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    xtal_i = 1'b0;
    forever begin
      repeat (4) @(posedge clk_i);
      xtal_i <= ~xtal_i;
    end
  end
  task finish_test;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready
  task xfer(input [11:0] a, input w, input [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd_v = prdata_o;
    err_v = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // align to a tick, then leave mask m
  task sync(input [31:0] m);
    xfer(`A_MASK, 1'b1, 32'h1);
    xfer(`A_STATUS, 1'b1, 32'h7f);
    repeat (2) @(posedge clk_i);
    for (int n = 0; n < 60 && irq_o !== 1'b1; n++) @(posedge clk_i);
    xfer(`A_MASK, 1'b1, m);
    xfer(`A_STATUS, 1'b1, 32'h7f);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    finish_test;
  end
  initial begin
    srst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    // reset values of all registers
    for (int i = 0; i < 9; i++) begin
      xfer(12'(i * 4), 1'b0, 32'h0);
      check(rd_v, 32'h0); // all zero
    end
    for (int i = 0; i < 7; i++) begin
      xfer(rows[i].a, 1'b1, rows[i].w);
      xfer(rows[i].a, 1'b0, 32'h0);
      check(rd_v, rows[i].r); // readback
      check({31'h0, err_v}, {31'h0, rows[i].e}); // unmapped
    end
    // full rollover of every stage
    xfer(`A_ALM1, 1'b1, 32'h0);
    xfer(`A_ALM2, 1'b1, 32'h0);
    xfer(`A_ALM2_DAY, 1'b1, 32'h0);
    sync(32'h0);
    xfer(`A_TIME, 1'b1, 32'h00173b3a);
    xfer(`A_DAY, 1'b1, 32'h7fff);
    repeat (2 * TK) @(posedge clk_i);
    xfer(`A_TIME, 1'b0, 32'h0);
    check(rd_v, 32'h0); // wrap carry
    xfer(`A_DAY, 1'b0, 32'h0);
    check(rd_v, 32'h0); // days wrap
    xfer(`A_STATUS, 1'b0, 32'h0);
    check(rd_v, 32'h3f); // all periodic and both alarms
    // alarms on wrong and right day
    xfer(`A_ALM1, 1'b1, 32'h000a1405);
    xfer(`A_ALM2, 1'b1, 32'h000a1405);
    xfer(`A_ALM2_DAY, 1'b1, 32'h5);
    for (int d = 3; d <= 5; d += 2) begin
      sync(d == 3 ? 32'h10 : 32'h0);
      xfer(`A_TIME, 1'b1, 32'h000a1404);
      xfer(`A_DAY, 1'b1, 32'(d));
      repeat (TK) @(posedge clk_i);
      check({31'h0, irq_o}, {31'h0, d == 3}); // masked
      check({31'h0, wake_o}, {31'h0, d == 3}); // wake
      xfer(`A_STATUS, 1'b0, 32'h0);
      check(rd_v, d == 3 ? 32'h11 : 32'h31); // day compare
    end
    // stopwatch countdown and underflow
    sync(32'h40);
    xfer(`A_SW, 1'b1, 32'h2);
    xfer(`A_CTRL, 1'b1, 32'h1);
    repeat (2 * TK) @(posedge clk_i);
    xfer(`A_SW, 1'b0, 32'h0);
    check(rd_v, 32'h0); // decrement
    check({31'h0, irq_o}, 32'h0); // no event yet
    xfer(`A_STATUS, 1'b1, 32'h7f);
    repeat (TK) @(posedge clk_i);
    xfer(`A_SW, 1'b0, 32'h0);
    check(rd_v, 32'hffff); // wrap
    xfer(`A_STATUS, 1'b0, 32'h0);
    check(rd_v, 32'h41); // event
    xfer(`A_CTRL, 1'b1, 32'h0);
    repeat (TK) @(posedge clk_i);
    xfer(`A_SW, 1'b0, 32'h0);
    check(rd_v, 32'hffff); // stopped
    // mid-run reset with the interrupt raised
    xfer(`A_MASK, 1'b1, 32'h7f);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1); // pending before reset
    srst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    check({31'h0, irq_o}, 32'h0); // reset drops irq
    check({31'h0, wake_o}, 32'h0); // reset drops wake
    xfer(`A_TIME, 1'b0, 32'h0);
    check(rd_v, 32'h0); // time cleared
    xfer(`A_SW, 1'b0, 32'h0);
    check(rd_v, 32'h0); // stopwatch cleared
    xfer(`A_STATUS, 1'b0, 32'h0);
    check(rd_v, 32'h0); // status cleared
    xfer(`A_MASK, 1'b0, 32'h0);
    check(rd_v, 32'h0); // mask cleared
    finish_test;
  end
endmodule // rtc_watch_alarm_stopwatch_bench
